// ---- asr_consts.svh ----
// Constants of the asynchronous serial receiver: register offsets, widths, resets, timing.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses on the low address bits.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

`define ASR_ADR_W 4
`define ASR_OFS_CTRL 4'h0
`define ASR_OFS_STAT 4'h4
`define ASR_OFS_DATA 4'h8
`define ASR_OFS_BAUD 4'hc

`define ASR_CTRL_W 9
`define ASR_CTRL_RST 9'h000
`define ASR_BAUD_W 16
`define ASR_BAUD_RST 16'h0000

`define ASR_OVS_W 4
`define ASR_OVS_LAST 4'hf
`define ASR_OVS_FIRST 4'h0
`define ASR_MID_PHASE 4'h9
`define ASR_BITS_8 4'h8
`define ASR_BITS_9 4'h9
`define ASR_BCNT_ONE 4'h1
`define ASR_ZERO_32 32'h0000_0000

`endif

// ---- asr_pkg.sv ----
// Types of the asynchronous serial receiver: control fields and the stored character.
// Assumes asr_consts.svh is available on the include path.
`include "asr_consts.svh"

package asr_pkg;

    typedef struct packed {
        logic global_int_enable;
        logic peripheral_int_enable;
        logic receive_int_enable;
        logic clocked_mode_select;
        logic receive_polarity_bit;
        logic address_detect_enable;
        logic nine_bit_receive_enable;
        logic receive_enable_bit;
        logic port_enable_bit;
    } asr_ctrl_t;

    typedef struct packed {
        logic frame_error;
        logic [8:0] data;
    } asr_entry_t;

    typedef enum logic [1:0] {
        ASR_IDLE,
        ASR_START,
        ASR_DATA,
        ASR_STOP
    } asr_state_t;

endpackage : asr_pkg

// ---- asr_receiver.sv ----
// Asynchronous serial receiver with 16x oversampling, two-entry FIFO and Wishbone registers.
// Assumes one 10 MHz clock, a synchronous active-high reset and a classic Wishbone master.
`timescale 1ns/1ps
`include "asr_consts.svh"

// Function
// - Sixteen samples per bit recover data; the shift register advances once per bit.
// - A complete 8 or 9 bit character moves at once into a two-entry FIFO.
// - Port enable forces the serial output pin driven and disconnects the port latch.
// - Reception starts on a falling receive edge while idle; start bit is zero.
// - Half a bit later the start must still be zero, else abandon silently.
// - Each later bit centre is one bit time on, voted by majority, then shifted.
// - One more bit is the stop bit; a zero there marks a framing error.
// - At the stop bit centre the character is pushed; each data read pops one.
// - A third character with a full FIFO sets overrun and blocks further characters.
// - Overrun clears only by clearing receive enable or port enable.
// - Polarity bit one inverts received idle and data in asynchronous mode.
// - Available flag is receiver enabled and FIFO not empty; software cannot change it.
// - Interrupt request needs available flag and all three interrupt enables.
// - Each entry keeps its framing error; the flag shows the oldest entry.
// - Framing error is read-only, cleared by a data read or by port enable, never blocks reception.
// - Nine-bit mode shifts nine bits and shows the ninth in a status bit.
// - Address detection in nine-bit mode keeps only characters whose ninth bit is one.
module asr_receiver #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ASR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_in_pin_i,
    input wire logic port_latch_i,
    input wire logic pin_direction_bit_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n_o,
    output logic rx_irq_o
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction : majority

    asr_pkg::asr_ctrl_t ctrl_r;
    logic [`ASR_BAUD_W-1:0] baud_r;
    logic [`ASR_BAUD_W-1:0] baud_cnt_r;
    logic tick_r;
    logic in_meta_r;
    logic in_sync_r;
    logic [1:0] hist_r;
    logic [`ASR_OVS_W-1:0] phase_r;
    logic [3:0] bit_cnt_r;
    logic [8:0] receive_shift_reg_r;
    asr_pkg::asr_state_t state_r;
    asr_pkg::asr_entry_t fifo_r [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] count_r;
    logic overrun_flag_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic irq_r;
    logic out_pin_r;
    logic out_oe_n_r;

    // Wishbone decode; the answer comes one cycle after the request.
    wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire logic wr_ctrl = wb_req & wb_we_i & (wb_adr_i == `ASR_OFS_CTRL);
    wire logic wr_baud = wb_req & wb_we_i & (wb_adr_i == `ASR_OFS_BAUD);
    wire logic rd_data = wb_req & ~wb_we_i & (wb_adr_i == `ASR_OFS_DATA);

    // Port enable acts as the serial port reset; clearing it wipes all receive state.
    wire logic port_on = ctrl_r.port_enable_bit;
    wire logic rx_active = port_on & ctrl_r.receive_enable_bit & ~ctrl_r.clocked_mode_select;
    wire logic fifo_empty = (count_r == '0);
    wire logic fifo_full = (count_r == (PTR_W+1)'(FIFO_DEPTH));
    wire asr_pkg::asr_entry_t top_entry = fifo_r[rd_ptr_r];
    wire logic char_available_flag = ctrl_r.receive_enable_bit & ~fifo_empty;
    wire logic pop = rd_data & ~fifo_empty;

    // Polarity applies only in asynchronous mode.
    wire logic line = in_sync_r ^ (ctrl_r.receive_polarity_bit
                                   & ~ctrl_r.clocked_mode_select);
    wire logic vote = majority(hist_r[1], hist_r[0], line);
    wire logic at_mid = tick_r & (phase_r == `ASR_MID_PHASE);
    wire logic [3:0] char_bits = ctrl_r.nine_bit_receive_enable ? `ASR_BITS_9 : `ASR_BITS_8;
    wire logic [8:0] char_data = ctrl_r.nine_bit_receive_enable ? receive_shift_reg_r
                                 : {1'b0, receive_shift_reg_r[8:1]};
    // Gated by rx_active so a stop centre in the cycle that disables the receiver stores nothing.
    wire logic stop_done = at_mid & (state_r == asr_pkg::ASR_STOP) & rx_active;
    wire logic addr_drop = ctrl_r.address_detect_enable & ctrl_r.nine_bit_receive_enable
                           & ~char_data[8];
    wire logic push = stop_done & ~overrun_flag_r & ~fifo_full & ~addr_drop;
    wire logic set_overrun = stop_done & ~overrun_flag_r & fifo_full & ~addr_drop;

    wire logic [31:0] stat_word = {27'h0000000, ~(state_r == asr_pkg::ASR_IDLE),
                                   char_available_flag, top_entry.data[8] & ~fifo_empty,
                                   overrun_flag_r,
                                   top_entry.frame_error & ~fifo_empty};
    wire logic [31:0] rd_word = (wb_adr_i == `ASR_OFS_CTRL) ? {23'h000000, ctrl_r}
                              : (wb_adr_i == `ASR_OFS_STAT) ? stat_word
                              : (wb_adr_i == `ASR_OFS_DATA) ? {24'h000000, top_entry.data[7:0]}
                              : (wb_adr_i == `ASR_OFS_BAUD) ? {16'h0000, baud_r}
                              : `ASR_ZERO_32;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            rdat_r <= `ASR_ZERO_32;
        end
        else
        begin
            ack_r <= wb_req;
            rdat_r <= (wb_req & ~wb_we_i) ? rd_word : `ASR_ZERO_32;
        end
    end

    // Writes honour byte lanes 0 and 1 for control and lanes 0 and 1 for the divisor.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= asr_pkg::asr_ctrl_t'(`ASR_CTRL_RST);
            baud_r <= `ASR_BAUD_RST;
        end
        else
        begin
            if (wr_ctrl & wb_sel_i[0])
            begin
                ctrl_r[7:0] <= wb_dat_i[7:0];
            end
            if (wr_ctrl & wb_sel_i[1])
            begin
                ctrl_r[8] <= wb_dat_i[8];
            end
            if (wr_baud & wb_sel_i[0])
            begin
                baud_r[7:0] <= wb_dat_i[7:0];
            end
            if (wr_baud & wb_sel_i[1])
            begin
                baud_r[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // The 16x sample enable; the divisor sets the tick period to divisor plus one clocks.
    always_ff @(posedge clk_i)
    begin
        if (rst_i | ~rx_active)
        begin
            baud_cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (baud_cnt_r == baud_r);
            baud_cnt_r <= (baud_cnt_r == baud_r) ? '0 : baud_cnt_r + 1'b1;
        end
    end

    // Two flip-flops guard the asynchronous receive pin.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_meta_r <= 1'b1;
            in_sync_r <= 1'b1;
        end
        else
        begin
            in_meta_r <= serial_in_pin_i;
            in_sync_r <= in_meta_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i | ~rx_active)
        begin
            state_r <= asr_pkg::ASR_IDLE;
            hist_r <= 2'b11;
            phase_r <= `ASR_OVS_FIRST;
            bit_cnt_r <= '0;
            receive_shift_reg_r <= '0;
        end
        else if (tick_r)
        begin
            hist_r <= {hist_r[0], line};
            phase_r <= (phase_r == `ASR_OVS_LAST) ? `ASR_OVS_FIRST : phase_r + 1'b1;
            unique case (state_r)
                asr_pkg::ASR_IDLE:
                begin
                    if (hist_r[0] & ~line)
                    begin
                        state_r <= asr_pkg::ASR_START;
                        phase_r <= `ASR_OVS_FIRST + 1'b1;
                    end
                end
                asr_pkg::ASR_START:
                begin
                    if (at_mid)
                    begin
                        bit_cnt_r <= '0;
                        state_r <= vote ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DATA;
                    end
                end
                asr_pkg::ASR_DATA:
                begin
                    if (at_mid)
                    begin
                        receive_shift_reg_r <= {vote, receive_shift_reg_r[8:1]};
                        bit_cnt_r <= bit_cnt_r + `ASR_BCNT_ONE;
                        if (bit_cnt_r + `ASR_BCNT_ONE == char_bits)
                        begin
                            state_r <= asr_pkg::ASR_STOP;
                        end
                    end
                end
                asr_pkg::ASR_STOP:
                begin
                    if (at_mid)
                    begin
                        state_r <= asr_pkg::ASR_IDLE;
                    end
                end
            endcase
        end
    end

    // The FIFO survives a cleared receive enable so that the framing flags stay readable.
    always_ff @(posedge clk_i)
    begin
        if (rst_i | ~port_on)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            for (int i = 0; i < FIFO_DEPTH; i++)
            begin
                fifo_r[i] <= '0;
            end
        end
        else
        begin
            if (push)
            begin
                fifo_r[wr_ptr_r] <= '{frame_error: ~vote, data: char_data};
                wr_ptr_r <= (wr_ptr_r == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // Overrun only sets while the receiver runs, so the clear and a set never meet.
    always_ff @(posedge clk_i)
    begin
        if (rst_i | ~port_on | ~ctrl_r.receive_enable_bit)
        begin
            overrun_flag_r <= 1'b0;
        end
        else if (set_overrun)
        begin
            overrun_flag_r <= 1'b1;
        end
    end

    // The pin stays driven high while enabled because this block has no transmitter.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_r <= 1'b0;
            out_pin_r <= 1'b1;
            out_oe_n_r <= 1'b1;
        end
        else
        begin
            irq_r <= char_available_flag & ctrl_r.receive_int_enable
                     & ctrl_r.peripheral_int_enable & ctrl_r.global_int_enable;
            out_pin_r <= port_on ? 1'b1 : port_latch_i;
            out_oe_n_r <= port_on ? 1'b0 : pin_direction_bit_i;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign rx_irq_o = irq_r;
    assign serial_out_pin_o = out_pin_r;
    assign serial_out_pin_oe_n_o = out_oe_n_r;

endmodule : asr_receiver

// ---- asr_receiver_props.sv ----
// Checker of the receiver's bus handshake, pin ownership and flag gating.
// Assumes bus traffic with all byte lanes enabled.
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_receiver_props #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ASR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic serial_in_pin_i,
    input wire logic port_latch_i,
    input wire logic pin_direction_bit_i,
    input wire logic serial_out_pin_o,
    input wire logic serial_out_pin_oe_n_o,
    input wire logic rx_irq_o
);
    logic [8:0] ctrl_r;
    logic [1:0] pe_h_r;
    logic [1:0] re_h_r;
    logic rst_d_r;
    // The shadow lags the real control register, so gating checks want some history.
    wire logic pe_on = ctrl_r[0] && pe_h_r[0] && !rst_d_r;
    wire logic pe_off = !ctrl_r[0] && pe_h_r == 2'h0 && !rst_d_r;
    wire logic re_off = !ctrl_r[1] && re_h_r == 2'h0;
    always_ff @(posedge clk_i)
    begin
        rst_d_r <= rst_i;
        pe_h_r <= {pe_h_r[0], ctrl_r[0]};
        re_h_r <= {re_h_r[0], ctrl_r[1]};
        if (rst_i)
            ctrl_r <= `ASR_CTRL_RST;
        else if (wb_ack_o && wb_we_i && wb_adr_i == `ASR_OFS_CTRL)
            ctrl_r <= wb_dat_i[8:0];
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_stat;
        wb_ack_o && !wb_we_i && wb_adr_i == `ASR_OFS_STAT;
    endsequence
    property p_ack_in_one;
        s_take |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_wr_zero;
        wb_ack_o && wb_we_i |-> wb_dat_o == `ASR_ZERO_32;
    endproperty
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == `ASR_ZERO_32;
    endproperty
    property p_pin_drive;
        pe_on |-> !$past(serial_out_pin_oe_n_o) && $past(serial_out_pin_o);
    endproperty
    property p_pin_free;
        pe_off && !$past(rst_d_r) |-> $past(serial_out_pin_oe_n_o) == $past(pin_direction_bit_i, 2);
    endproperty
    property p_irq_gate;
        rx_irq_o |-> ctrl_r[8:6] == 3'h7 && ctrl_r[1];
    endproperty
    property p_port_off;
        s_rd_stat ##0 pe_off |-> wb_dat_o[3:0] == 4'h0;
    endproperty
    property p_rx_off;
        s_rd_stat ##0 re_off |-> !wb_dat_o[3] && !wb_dat_o[1];
    endproperty
    a_ack_in_one: assert property (p_ack_in_one) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    a_wr_zero: assert property (p_wr_zero) else $error("write data out");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");
    a_pin_free: assert property (p_pin_free) else $error("pin not freed");
    a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
    a_port_off: assert property (p_port_off) else $error("flags kept");
    a_rx_off: assert property (p_rx_off) else $error("rx flags kept");
endmodule : asr_receiver_props

bind asr_receiver asr_receiver_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);

// ---- asr_tx_model.sv ----
// Remote transmitter model driving the receive line, LSB first.
// Assumes the bench sets the bit length to match the divisor; 16 clocks suit a zero divisor.
`timescale 1ns/1ps
module asr_tx_model (
    input wire logic clk_i,
    output logic line_o
);
    logic inv_r = 1'b0;
    int bit_clks_r = 16;
    initial line_o = 1'b1;
    task automatic drive(input logic lvl, input int clks);
        @(posedge clk_i);
        line_o <= lvl ^ inv_r;
        repeat (clks - 1) @(posedge clk_i);
    endtask : drive
    task automatic send(input logic [8:0] d, input int n, input logic stop, input int gap);
        drive(1'b0, bit_clks_r);
        for (int i = 0; i < n; i++)
            drive(d[i], bit_clks_r);
        drive(stop, bit_clks_r);
        drive(1'b1, gap);
    endtask : send
endmodule : asr_tx_model

// ---- tb_async_serial_receiver.sv ----
// Bench for the serial receiver: bus, framing, FIFO, flags and pins.
// Assumes the transmitter model and the bound checker.
`timescale 1ns/1ps
`include "asr_consts.svh"
module tb_async_serial_receiver;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic line;
    logic latch = 1'b0;
    logic dir = 1'b1;
    logic pin;
    logic oe_n;
    logic irq;
    logic [31:0] rd;
    logic [8:0] v;
    int err_total = 0;
    int samples_checked = 0;
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    asr_receiver uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(cyc),
        .wb_stb_i(cyc),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(4'hf),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .serial_in_pin_i(line),
        .port_latch_i(latch),
        .pin_direction_bit_i(dir),
        .serial_out_pin_o(pin),
        .serial_out_pin_oe_n_o(oe_n),
        .rx_irq_o(irq)
    );
    asr_tx_model tx (
        .clk_i(clk_i),
        .line_o(line)
    );
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
            err_total++;
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        chk({31'h0, ack}, 32'h1);
        rd = rdat;
        cyc <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    function automatic logic [31:0] st(input logic f, o, n, a);
        return {28'h0, a, n, o, f};
    endfunction : st
    task automatic got(input logic [8:0] d, input logic f, input logic o);
        rdc(`ASR_OFS_STAT, st(f, o, d[8], 1'b1));
        rdc(`ASR_OFS_DATA, {24'h0, d[7:0]});
    endtask : got
    task automatic snd(input logic [8:0] d, input int n, input logic s);
        tx.send(d, n, s, 4 + int'($urandom_range(16)));
    endtask : snd
    task automatic irqc(input logic e);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irqc
    task automatic pins(input logic en);
        @(posedge clk_i);
        dir <= 1'($urandom);
        latch <= 1'($urandom);
        repeat (3) @(posedge clk_i);
        chk({30'h0, oe_n, pin}, {30'h0, !en && dir, en || latch});
    endtask : pins
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #(20000 * 100);
        err_total++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(75));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`ASR_OFS_CTRL, 32'h0);
        rdc(`ASR_OFS_BAUD, 32'h0);
        rdc(4'h2, 32'h0);
        bus(1'b1, `ASR_OFS_STAT, 32'hffff_ffff);
        rdc(`ASR_OFS_STAT, st(0, 0, 0, 0));
        pins(1'b0);
        bus(1'b1, `ASR_OFS_CTRL, 32'h023);
        snd(9'h05a, 8, 1'b1);
        bus(1'b1, `ASR_OFS_CTRL, 32'h003);
        rdc(`ASR_OFS_STAT, st(0, 0, 0, 0));
        pins(1'b1);
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 9'h000 : (i == 1) ? 9'h0ff : {1'b0, 8'($urandom)};
            snd(v, 8, 1'b1);
            got(v, 1'b0, 1'b0);
        end
        snd(9'h0a5, 8, 1'b0);
        snd(9'h03c, 8, 1'b1);
        bus(1'b1, `ASR_OFS_CTRL, 32'h001);
        rdc(`ASR_OFS_STAT, st(1, 0, 0, 0));
        bus(1'b1, `ASR_OFS_CTRL, 32'h003);
        got(9'h0a5, 1'b1, 1'b0);
        got(9'h03c, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++)
            snd(9'(8'h40 + i), 8, 1'b1);
        got(9'h040, 1'b0, 1'b1);
        got(9'h041, 1'b0, 1'b1);
        rdc(`ASR_OFS_STAT, st(0, 1, 0, 0));
        bus(1'b1, `ASR_OFS_CTRL, 32'h001);
        bus(1'b1, `ASR_OFS_CTRL, 32'h003);
        rdc(`ASR_OFS_STAT, st(0, 0, 0, 0));
        tx.drive(1'b0, 4);
        tx.drive(1'b1, 30);
        rdc(`ASR_OFS_STAT, st(0, 0, 0, 0));
        bus(1'b1, `ASR_OFS_BAUD, 32'h0000_0001);
        rdc(`ASR_OFS_BAUD, 32'h0000_0001);
        tx.bit_clks_r = 32;
        v = {1'b0, 8'($urandom)};
        snd(v, 8, 1'b1);
        got(v, 1'b0, 1'b0);
        bus(1'b1, `ASR_OFS_BAUD, 32'h0000_0000);
        tx.bit_clks_r = 16;
        bus(1'b1, `ASR_OFS_CTRL, 32'h00f);
        snd(9'h055, 9, 1'b1);
        snd(9'h1a3, 9, 1'b1);
        got(9'h1a3, 1'b0, 1'b0);
        bus(1'b1, `ASR_OFS_CTRL, 32'h007);
        snd(9'h055, 9, 1'b1);
        got(9'h055, 1'b0, 1'b0);
        bus(1'b1, `ASR_OFS_CTRL, 32'h011);
        tx.inv_r = 1'b1;
        tx.drive(1'b1, 8);
        bus(1'b1, `ASR_OFS_CTRL, 32'h013);
        snd(9'h0c4, 8, 1'b1);
        got(9'h0c4, 1'b0, 1'b0);
        bus(1'b1, `ASR_OFS_CTRL, 32'h001);
        tx.inv_r = 1'b0;
        tx.drive(1'b1, 8);
        bus(1'b1, `ASR_OFS_CTRL, 32'h1c3);
        irqc(1'b0);
        snd(9'h017, 8, 1'b0);
        irqc(1'b1);
        bus(1'b1, `ASR_OFS_CTRL, 32'h0c3);
        irqc(1'b0);
        bus(1'b1, `ASR_OFS_CTRL, 32'h000);
        rdc(`ASR_OFS_STAT, st(0, 0, 0, 0));
        bus(1'b1, `ASR_OFS_CTRL, 32'h003);
        rdc(`ASR_OFS_STAT, st(0, 0, 0, 0));
        print_verdict();
    end
endmodule : tb_async_serial_receiver
